/* logic/vmz_regs.svh */
// Register offsets, field positions, reset values and timing counts of the volume/mute control
`ifndef VMZ_REGS_SVH
`define VMZ_REGS_SVH

`define VMZ_ADDR_W        4
`define VMZ_OFF_VOL_L     4'h0
`define VMZ_OFF_VOL_R     4'h1
`define VMZ_OFF_CTRL      4'h2
`define VMZ_OFF_EFFECT    4'h3
`define VMZ_OFF_ALIGN_CTL 4'h4
`define VMZ_OFF_ALIGN_IN1 4'h5
`define VMZ_OFF_ALIGN_IN2 4'h6
`define VMZ_OFF_TIMING    4'h7
`define VMZ_OFF_STATUS    4'h8

`define VMZ_VOL_MAX       7'h00
`define VMZ_VOL_M71       7'h57
`define VMZ_VOL_MUTE      7'h58
`define VMZ_VOL_M12       7'h1c
`define VMZ_VOL_RST       7'h10

`define VMZ_CTRL_GMU      0
`define VMZ_CTRL_MUTE_TIMING_SELECT     1
`define VMZ_CTRL_CCD      2
`define VMZ_CTRL_AVL_OFF  3
`define VMZ_CTRL_ATK_LSB  4
`define VMZ_CTRL_LOUD     6
`define VMZ_CTRL_RST      8'h01

`define VMZ_EFF_MODE_LSB  0
`define VMZ_EFF_SPAT52    2
`define VMZ_EFF_RST       8'h00

`define VMZ_ALIGN_MID     5'h10
`define VMZ_TIMING_RST    3'h3

`define VMZ_CLK_MHZ       125
`define VMZ_FAST_CHG_MS   2000
`define VMZ_FAST_CHG_CYC  (`VMZ_FAST_CHG_MS * `VMZ_CLK_MHZ * 1000)

`endif

/* logic/vmz_pkg.sv */
// Types shared by the volume/mute control block
package vmz_pkg;

  typedef enum logic [1:0] {
    VMZ_EFF_LINEAR,
    VMZ_EFF_PSEUDO,
    VMZ_EFF_SPATIAL,
    VMZ_EFF_MONO
  } vmz_effect_e;

  typedef enum logic {
    VMZ_AL_IDLE,
    VMZ_AL_RUN
  } vmz_align_e;

  typedef struct packed {
    logic [6:0] pend;
    logic       pend_v;
    logic [6:0] appl;
  } vmz_chan_s;

  typedef struct packed {
    logic       gmu_pend;
    logic       gmu_pend_v;
    logic       gmu_appl;
  } vmz_mute_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } vmz_bus_s;

  typedef struct packed {
    logic [6:0] vol_l;
    logic [6:0] vol_r;
    logic       mute_l;
    logic       mute_r;
    logic       loud_on;
    logic [4:0] loud_boost_l;
    logic [4:0] loud_boost_r;
    logic       avl_off;
    logic [1:0] attack_sel;
    logic       fast_charge;
    logic [1:0] effect_mode;
    logic       spatial_52;
    logic       align_run;
    logic [4:0] spectral_trim;
    logic [4:0] wideband_trim;
    logic [2:0] timing_trim;
  } vmz_analog_s;

endpackage

/* logic/vmz_ctrl.sv */
// Volume, mute, effects and alignment control of the audio output stage
//
// Functional notes
// - Volume +16 to -71 dB, 1 dB, mute code
// - Separate left and right volume settings
// - Loudness enable; full boost at -12 dB
// - New volume waits for channel zero crossing
// - Pending value applied before newer takes place
// - Next volume write forces pending value
// - Step into mute code skips zero-cross wait
// - Global mute silences all outputs
// - Mute timing select: forced or zero-cross
// - Zero-cross mode defers global mute change
// - Level control disable and attack ratio setting
// - Fast charge boosts current first 2 s
// - Effects mode select and spatial crosstalk
// - Alignment overwrites alignment input registers
// - Writable noise-reduction timing current trim
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "vmz_regs.svh"

module vmz_ctrl #(
  parameter int unsigned FAST_CHG_CYC = `VMZ_FAST_CHG_CYC
) (
  // Clock and reset
  input  wire  logic                 mclk,
  input  wire  logic                 rst_n,
  // Register port
  input  wire  logic [3:0]           reg_addr,
  input  wire  logic [7:0]           reg_wdata,
  input  wire  logic                 reg_wr,
  input  wire  logic                 reg_rd,
  output logic       [7:0]           reg_rdata,
  // Zero-crossing detector pulses
  input  wire  logic                 zc_left,
  input  wire  logic                 zc_right,
  // Alignment results from the decoder
  input  wire  logic                 align_done,
  input  wire  logic [4:0]           align_result_first,
  input  wire  logic [4:0]           align_result_second,
  // Settings to the analog path
  output vmz_pkg::vmz_analog_s       analog
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    vmz_pkg::vmz_chan_s  ch_l;
    vmz_pkg::vmz_chan_s  ch_r;
    vmz_pkg::vmz_mute_s  mute;
    logic [7:0]          ctrl;
    logic [7:0]          effect;
    vmz_pkg::vmz_align_e align;
    logic [4:0]          align_in1;
    logic [4:0]          align_in2;
    logic [2:0]          timing;
    logic                fast_active;
    logic [31:0]         fast_cnt;
    logic [7:0]          rdata;
  } vmz_state_s;

  vmz_state_s st_r;
  vmz_state_s st_nxt;
  vmz_pkg::vmz_bus_s bus;

  assign bus.wr    = reg_wr;
  assign bus.rd    = reg_rd;
  assign bus.addr  = reg_addr;
  assign bus.wdata = reg_wdata;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Clamp written codes to the legal range, anything past mute is mute
  function automatic logic [6:0] vmz_clamp(input logic [7:0] d);
    vmz_clamp = (d > {1'b0, `VMZ_VOL_MUTE}) ? `VMZ_VOL_MUTE : d[6:0];
  endfunction

  // One volume write or zero crossing on a channel
  function automatic vmz_pkg::vmz_chan_s vmz_chan_step(
    input vmz_pkg::vmz_chan_s c,
    input logic               zc,
    input logic               wr,
    input logic [6:0]         code
  );
    vmz_pkg::vmz_chan_s n;
    n = c;
    if (zc && c.pend_v) begin
      n.appl   = c.pend;
      n.pend_v = 1'b0;
    end
    if (wr) begin
      if (c.pend_v) begin
        n.appl = c.pend;
      end
      if (code == `VMZ_VOL_MUTE) begin
        n.appl   = code;
        n.pend_v = 1'b0;
      end else begin
        n.pend   = code;
        n.pend_v = 1'b1;
      end
    end
    vmz_chan_step = n;
  endfunction

  function automatic logic [4:0] vmz_boost(input logic [6:0] v);
    if (v >= `VMZ_VOL_M12) begin
      vmz_boost = 5'h1c;
    end else begin
      vmz_boost = v[4:0];
    end
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic       wr_vol_l;
  logic       wr_vol_r;
  logic       wr_ctrl;
  logic       zc_any;

  always_comb begin
    st_nxt   = st_r;
    wr_vol_l = bus.wr && (bus.addr == `VMZ_OFF_VOL_L);
    wr_vol_r = bus.wr && (bus.addr == `VMZ_OFF_VOL_R);
    wr_ctrl  = bus.wr && (bus.addr == `VMZ_OFF_CTRL);
    zc_any   = zc_left || zc_right;

    st_nxt.ch_l = vmz_chan_step(st_r.ch_l, zc_left, wr_vol_l, vmz_clamp(bus.wdata));
    st_nxt.ch_r = vmz_chan_step(st_r.ch_r, zc_right, wr_vol_r, vmz_clamp(bus.wdata));

    if (st_r.mute.gmu_pend_v && (zc_any || !st_r.ctrl[`VMZ_CTRL_MUTE_TIMING_SELECT])) begin
      st_nxt.mute.gmu_appl   = st_r.mute.gmu_pend;
      st_nxt.mute.gmu_pend_v = 1'b0;
    end
    if (wr_ctrl) begin
      st_nxt.ctrl = bus.wdata;
      if (bus.wdata[`VMZ_CTRL_GMU] != st_nxt.mute.gmu_appl) begin
        if (bus.wdata[`VMZ_CTRL_MUTE_TIMING_SELECT]) begin
          st_nxt.mute.gmu_pend   = bus.wdata[`VMZ_CTRL_GMU];
          st_nxt.mute.gmu_pend_v = 1'b1;
        end else begin
          st_nxt.mute.gmu_appl   = bus.wdata[`VMZ_CTRL_GMU];
          st_nxt.mute.gmu_pend_v = 1'b0;
        end
      end else begin
        st_nxt.mute.gmu_pend_v = 1'b0;
      end
    end

    if (st_r.fast_active) begin
      if (st_r.fast_cnt == FAST_CHG_CYC - 1) begin
        st_nxt.fast_active = 1'b0;
      end else begin
        st_nxt.fast_cnt = st_r.fast_cnt + 32'h1;
      end
    end

    if (bus.wr) begin
      unique case (bus.addr)
        `VMZ_OFF_EFFECT:    st_nxt.effect    = bus.wdata;
        `VMZ_OFF_ALIGN_CTL: st_nxt.align     = bus.wdata[0] ? vmz_pkg::VMZ_AL_RUN : vmz_pkg::VMZ_AL_IDLE;
        `VMZ_OFF_ALIGN_IN1: st_nxt.align_in1 = bus.wdata[4:0];
        `VMZ_OFF_ALIGN_IN2: st_nxt.align_in2 = bus.wdata[4:0];
        `VMZ_OFF_TIMING:    st_nxt.timing    = bus.wdata[2:0];
        default: ;
      endcase
    end

    if (st_r.align == vmz_pkg::VMZ_AL_RUN && align_done) begin
      st_nxt.align_in1 = align_result_first;
      st_nxt.align_in2 = align_result_second;
    end

    st_nxt.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `VMZ_OFF_VOL_L:     st_nxt.rdata = {1'b0, st_r.ch_l.appl};
        `VMZ_OFF_VOL_R:     st_nxt.rdata = {1'b0, st_r.ch_r.appl};
        `VMZ_OFF_CTRL:      st_nxt.rdata = st_r.ctrl;
        `VMZ_OFF_EFFECT:    st_nxt.rdata = st_r.effect;
        `VMZ_OFF_ALIGN_CTL: st_nxt.rdata = {7'h00, st_r.align == vmz_pkg::VMZ_AL_RUN};
        `VMZ_OFF_ALIGN_IN1: st_nxt.rdata = {3'h0, st_r.align_in1};
        `VMZ_OFF_ALIGN_IN2: st_nxt.rdata = {3'h0, st_r.align_in2};
        `VMZ_OFF_TIMING:    st_nxt.rdata = {5'h00, st_r.timing};
        `VMZ_OFF_STATUS:    st_nxt.rdata = {4'h0, st_r.fast_active, st_r.mute.gmu_pend_v,
                                            st_r.ch_r.pend_v, st_r.ch_l.pend_v};
        default:            st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r             <= '0;
      st_r.ch_l.appl   <= `VMZ_VOL_RST;
      st_r.ch_l.pend   <= `VMZ_VOL_RST;
      st_r.ch_r.appl   <= `VMZ_VOL_RST;
      st_r.ch_r.pend   <= `VMZ_VOL_RST;
      st_r.mute.gmu_appl <= 1'b1;
      st_r.ctrl        <= `VMZ_CTRL_RST;
      st_r.effect      <= `VMZ_EFF_RST;
      st_r.align       <= vmz_pkg::VMZ_AL_IDLE;
      st_r.align_in1   <= `VMZ_ALIGN_MID;
      st_r.align_in2   <= `VMZ_ALIGN_MID;
      st_r.timing      <= `VMZ_TIMING_RST;
      st_r.fast_active <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = st_r.rdata;

  always_comb begin
    analog.vol_l         = st_r.ch_l.appl;
    analog.vol_r         = st_r.ch_r.appl;
    analog.mute_l        = st_r.mute.gmu_appl || (st_r.ch_l.appl == `VMZ_VOL_MUTE);
    analog.mute_r        = st_r.mute.gmu_appl || (st_r.ch_r.appl == `VMZ_VOL_MUTE);
    analog.loud_on       = st_r.ctrl[`VMZ_CTRL_LOUD];
    analog.loud_boost_l  = st_r.ctrl[`VMZ_CTRL_LOUD] ? vmz_boost(st_r.ch_l.appl) : 5'h00;
    analog.loud_boost_r  = st_r.ctrl[`VMZ_CTRL_LOUD] ? vmz_boost(st_r.ch_r.appl) : 5'h00;
    analog.avl_off       = st_r.ctrl[`VMZ_CTRL_AVL_OFF];
    analog.attack_sel    = st_r.ctrl[`VMZ_CTRL_ATK_LSB +: 2];
    analog.fast_charge   = st_r.ctrl[`VMZ_CTRL_CCD] && st_r.fast_active;
    analog.effect_mode   = st_r.effect[`VMZ_EFF_MODE_LSB +: 2];
    analog.spatial_52    = st_r.effect[`VMZ_EFF_SPAT52];
    analog.align_run     = (st_r.align == vmz_pkg::VMZ_AL_RUN);
    analog.spectral_trim = st_r.align_in1;
    analog.wideband_trim = st_r.align_in2;
    analog.timing_trim   = st_r.timing;
  end

endmodule
`default_nettype wire

/* verif/vmz_host.sv */
// Host model that issues register reads and writes
`timescale 1ns/100ps
`default_nettype none
module vmz_host (
  // Clock
  input  wire logic       mclk,
  // Register port
  output var  logic [3:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  // ********
  // Bus tasks
  // ********
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/vmz_ctrl_properties.sv */
// Port assertions of the volume/mute control
`timescale 1ns/100ps
`default_nettype none
`include "vmz_regs.svh"
module vmz_ctrl_properties (
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // Register port
  input wire logic [3:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  // Detectors and decoder
  input wire logic                 zc_left,
  input wire logic                 zc_right,
  input wire logic                 align_done,
  input wire logic [4:0]           align_result_first,
  input wire logic [4:0]           align_result_second,
  // Analog settings
  input wire vmz_pkg::vmz_analog_s analog
);
  // ********
  // Checks
  // ********
  logic wl;
  logic wc;
  logic we;
  assign wl = reg_wr && reg_addr == `VMZ_OFF_VOL_L;
  assign wc = reg_wr && reg_addr == `VMZ_OFF_CTRL;
  assign we = reg_wr && reg_addr == `VMZ_OFF_EFFECT;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  left_hold_a: assert property (!zc_left && !wl |=> $stable(analog.vol_l))
    else $error("left volume moved");
  mute_step_a: assert property (wl && reg_wdata == 8'h58 |=> analog.vol_l == `VMZ_VOL_MUTE)
    else $error("mute code not immediate");
  force_mute_a: assert property (wc && reg_wdata[1:0] == 2'b01 |=> analog.mute_l && analog.mute_r)
    else $error("forced mute missing");
  zc_mute_a: assert property (!zc_left && !zc_right && !reg_wr |=> $stable({analog.mute_l, analog.mute_r}))
    else $error("mute moved without crossing");
  loud_full_a: assert property (analog.loud_on && analog.vol_r inside {[7'h1c:7'h57]} |-> analog.loud_boost_r == 5'h1c)
    else $error("boost not full");
  loud_flat_a: assert property (!analog.loud_on || analog.vol_r == 7'h00 |-> analog.loud_boost_r == 5'h00)
    else $error("boost not flat");
  eff_set_a: assert property (we |=> {analog.spatial_52, analog.effect_mode} == $past(reg_wdata[2:0]))
    else $error("effect setting wrong");
  avl_set_a: assert property (wc |=> {analog.attack_sel, analog.avl_off} == $past(reg_wdata[5:3]))
    else $error("level setting wrong");
  cover property (zc_left ##1 reg_rd);
  cover property (wc && reg_wdata[1]);
  cover property (align_done && analog.align_run);
endmodule
bind vmz_ctrl vmz_ctrl_properties i_props (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .zc_left, .zc_right, .align_done, .align_result_first, .align_result_second, .analog);
`default_nettype wire

/* verif/vmz_ctrl_tb_top.sv */
// Self-checking bench of the volume/mute control
`timescale 1ns/100ps
`default_nettype none
`include "vmz_regs.svh"
module vmz_ctrl_tb_top;
  logic                 mclk = 1'b0;
  logic                 rst_n;
  logic                 zc_left;
  logic                 zc_right;
  logic                 align_done;
  logic [4:0]           res1;
  logic [4:0]           res2;
  logic [3:0]           reg_addr;
  logic [7:0]           reg_wdata;
  logic [7:0]           reg_rdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic                 rd_q = 1'b0;
  vmz_pkg::vmz_analog_s analog;
  logic [7:0]           exp_q[$];
  int                   fail_count = 0;
  int                   checks_done = 0;
  logic [6:0]           pd;
  logic [6:0]           ap;
  logic [6:0]           c;
  logic                 pv;
  logic                 z;
  always #4 mclk = ~mclk;
  vmz_host i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  vmz_ctrl #(.FAST_CHG_CYC(20)) i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .zc_left(zc_left), .zc_right(zc_right),
    .align_done(align_done), .align_result_first(res1), .align_result_second(res2), .analog(analog));
  // ********
  // Tasks
  // ********
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_host.wr(a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask
  task automatic pz(input logic l, input logic r);
    @(posedge mclk);
    zc_left <= l;
    zc_right <= r;
    @(posedge mclk);
    zc_left <= 1'b0;
    zc_right <= 1'b0;
  endtask
  always @(posedge mclk) begin
    if (rd_q) check(reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    zc_left = 1'b0;
    zc_right = 1'b0;
    align_done = 1'b0;
    res1 = 5'h00;
    res2 = 5'h00;
    void'($urandom(32'h5918ed89));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`VMZ_OFF_STATUS, 8'h08);
    rd(`VMZ_OFF_VOL_L, 8'h10);
    rd(`VMZ_OFF_CTRL, 8'h01);
    rd(`VMZ_OFF_ALIGN_IN1, 8'h10);
    rd(`VMZ_OFF_TIMING, 8'h03);
    wr(4'hf, 8'h5a);
    rd(4'hf, 8'h00);
    wr(`VMZ_OFF_CTRL, 8'h05);
    @(negedge mclk);
    check({7'h00, analog.fast_charge}, 8'h01);
    check({6'h00, analog.mute_l, analog.mute_r}, 8'h03);
    repeat (24) @(posedge mclk);
    @(negedge mclk);
    check({7'h00, analog.fast_charge}, 8'h00);
    wr(`VMZ_OFF_VOL_L, 8'h20);
    rd(`VMZ_OFF_VOL_L, 8'h10);
    rd(`VMZ_OFF_STATUS, 8'h01);
    wr(`VMZ_OFF_VOL_L, 8'h30);
    rd(`VMZ_OFF_VOL_L, 8'h20);
    pz(1'b1, 1'b0);
    rd(`VMZ_OFF_VOL_L, 8'h30);
    rd(`VMZ_OFF_VOL_R, 8'h10);
    wr(`VMZ_OFF_VOL_L, 8'h57);
    wr(`VMZ_OFF_VOL_L, 8'h58);
    rd(`VMZ_OFF_VOL_L, 8'h58);
    wr(`VMZ_OFF_CTRL, 8'h41);
    ap = 7'h10;
    pv = 1'b0;
    for (int i = 0; i < 12; i++) begin
      c = 7'($urandom_range(87));
      z = 1'($urandom);
      wr(`VMZ_OFF_VOL_R, {1'b0, c});
      if (pv) ap = pd;
      pd = c;
      pv = 1'b1;
      if (z) begin
        pz(1'b0, 1'b1);
        ap = pd;
        pv = 1'b0;
      end
      rd(`VMZ_OFF_VOL_R, {1'b0, ap});
      @(negedge mclk);
      check({1'b0, analog.vol_r}, {1'b0, ap});
      check({3'h0, analog.loud_boost_r}, (ap >= 7'h1c) ? 8'h1c : {3'h0, ap[4:0]});
    end
    wr(`VMZ_OFF_VOL_R, 8'h7f);
    rd(`VMZ_OFF_VOL_R, 8'h58);
    wr(`VMZ_OFF_CTRL, 8'h02);
    rd(`VMZ_OFF_STATUS, 8'h04);
    pz(1'b1, 1'b0);
    rd(`VMZ_OFF_STATUS, 8'h00);
    wr(`VMZ_OFF_CTRL, 8'h03);
    repeat (12) @(posedge mclk);
    wr(`VMZ_OFF_CTRL, 8'h01);
    rd(`VMZ_OFF_STATUS, 8'h00);
    wr(`VMZ_OFF_CTRL, 8'h03);
    rd(`VMZ_OFF_CTRL, 8'h03);
    for (int m = 0; m < 8; m++) begin
      wr(`VMZ_OFF_EFFECT, 8'(m));
      rd(`VMZ_OFF_EFFECT, 8'(m));
      wr(`VMZ_OFF_TIMING, 8'(m));
      rd(`VMZ_OFF_TIMING, 8'(m));
      @(negedge mclk);
      check({5'h00, analog.timing_trim}, 8'(m));
      c = {2'b00, 5'($urandom)};
      wr(`VMZ_OFF_CTRL, {c[5:0], 2'b11});
      rd(`VMZ_OFF_CTRL, {c[5:0], 2'b11});
    end
    wr(`VMZ_OFF_VOL_L, 8'h00);
    wr(`VMZ_OFF_VOL_R, 8'h00);
    pz(1'b1, 1'b1);
    wr(`VMZ_OFF_EFFECT, 8'h00);
    wr(`VMZ_OFF_CTRL, 8'h0b);
    @(negedge mclk);
    check({1'b0, analog.vol_l}, {1'b0, `VMZ_VOL_MAX});
    check({1'b0, analog.vol_r}, {1'b0, `VMZ_VOL_MAX});
    wr(`VMZ_OFF_ALIGN_CTL, 8'h01);
    @(negedge mclk);
    check({7'h00, analog.align_run}, 8'h01);
    @(posedge mclk);
    res1 <= 5'($urandom);
    res2 <= 5'($urandom);
    align_done <= 1'b1;
    @(posedge mclk);
    align_done <= 1'b0;
    wr(`VMZ_OFF_ALIGN_CTL, 8'h00);
    rd(`VMZ_OFF_ALIGN_IN1, {3'b000, res1});
    rd(`VMZ_OFF_ALIGN_IN2, {3'b000, res2});
    @(negedge mclk);
    check({3'h0, analog.spectral_trim}, {3'h0, res1});
    check({3'h0, analog.wideband_trim}, {3'h0, res2});
    check({7'h00, analog.align_run}, 8'h00);
    repeat (2) @(posedge mclk);
    print_verdict();
  end
endmodule
`default_nettype wire
